/* File: rtl/asr_pkg.sv */
// shared constants and state types for the serial converter readout
// assumes both ends run on one 250 MHz system clock
package asr_pkg;

  // ------------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------------
  localparam int RES_BITS   = 14;          // result bits per frame
  localparam int FRAME_BITS = 16;          // leading zeros plus result

  // ------------------------------------------------------------------
  // counts of serial clock falling edges
  // ------------------------------------------------------------------
  localparam logic [4:0] FALL_LAST   = 5'h10; // end of a full frame
  localparam logic [4:0] FALL_TRACK  = 5'h0F; // back to track after this
  localparam logic [4:0] FALL_PD_LO  = 5'h02; // power-down window opens
  localparam logic [4:0] FALL_PD_HI  = 5'h0A; // power-down window closes
  localparam logic [4:0] FALL_BURST  = 5'h08; // short power-down burst

  // ------------------------------------------------------------------
  // timing, host side serial clock made by a divider
  // ------------------------------------------------------------------
  localparam int MCLK_PS       = 4000;     // system clock period
  localparam int SCLK_HALF_NS  = 40;       // half serial clock period
  localparam int QUIET_NS      = 80;       // gap between two frames
  localparam logic [7:0] HALF_CYC  =
    8'((SCLK_HALF_NS * 1000) / MCLK_PS);
  localparam logic [7:0] QUIET_CYC =
    8'((QUIET_NS * 1000 + MCLK_PS - 1) / MCLK_PS);

  // ------------------------------------------------------------------
  // state types, gray coded along the usual path except the device's done to idle step
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    D_IDLE = 2'h0, D_CONV = 2'h1, D_DONE = 2'h3
  } asr_dev_state_type;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_LEAD = 2'h1, H_RUN = 2'h3, H_QUIET = 2'h2
  } asr_host_state_type;

endpackage

/* File: rtl/asr_link_if.sv */
// the three-wire serial link between converter and host
// the data line floats when the converter releases it; it reads high
`timescale 1ns/1ps
interface asr_link_if;
  logic cs_n;               // chip select, active low
  logic sclk;               // serial clock, made by the host
  logic serial_result_out;  // data driven by the converter
  logic sdo_oe_n;           // low while the converter drives data
  logic sdo_line;           // level seen on the wire

  // released line is pulled high, so no floating value reaches logic
  assign sdo_line = sdo_oe_n ? 1'b1 : serial_result_out;

  modport dev  (input cs_n, sclk, output serial_result_out, sdo_oe_n);
  modport host (output cs_n, sclk, input sdo_line);
endinterface

/* File: rtl/asr_fifo2.sv */
// small flop buffer with valid and ready on both sides
// assumes a power of two depth so that the pointers wrap by themselves
`timescale 1ns/1ps
module asr_fifo2 #(
  parameter int W = 14,       // word width
  parameter int D = 2         // entries
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(D);

  logic [W-1:0]  mem_q [D];   // storage
  logic [W-1:0]  mem_d [D];
  logic [AW-1:0] wp_q, wp_d;  // write index
  logic [AW-1:0] rp_q, rp_d;  // read index
  logic [AW:0]   cnt_q, cnt_d; // words held
  logic          push, pop;
  logic          valid_q, valid_d; // registered not-empty flag
  logic [W-1:0]  head_q, head_d;   // registered head word

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    in_ready  = (cnt_q != FULL);   // honest full
    out_valid = valid_q;           // both outputs leave from flops
    out_data  = head_q;
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    mem_d     = mem_q;
    wp_d      = wp_q;
    rp_d      = rp_q;
    cnt_d     = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d        = wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = rp_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
    valid_d = (cnt_d != '0);
    head_d  = mem_d[rp_d];
  end

  // ------------------------------------------------------------------
  // registers; storage needs no reset, only the indices, count and valid flag do
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    mem_q  <= mem_d;
    head_q <= head_d;
    if (!resetn) begin
      valid_q <= 1'b0;
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      valid_q <= valid_d;
    end
  end
endmodule

/* File: rtl/asr_device.sv */
// converter end of the serial readout: sample, shift, power modes
// assumes the link pins come from another clock domain and the sample
// word comes from logic on the system clock
// limitation: a serial clock half period must span several mclk
`timescale 1ns/1ps

module asr_device
  import asr_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                resetn,
  asr_link_if.dev                  link,
  input  wire logic [RES_BITS-1:0] sample_in,
  output logic                     track_q,
  output logic                     powered_q,
  output logic                     frame_done_q
);

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic cs_s1_q, cs_s2_q, cs_s3_q;       // select, two stages plus edge
  logic sk_s1_q, sk_s2_q, sk_s3_q;       // serial clock likewise
  logic cs_fall, cs_rise;                // select edges
  logic sk_fall, sk_rise;                // serial clock edges

  // reset to the idle levels so that no false edge follows reset
  // the first stage feeds only the second; edges look at stages 2 and 3
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      sk_s1_q <= 1'b1;
      sk_s2_q <= 1'b1;
      sk_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= link.cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      sk_s1_q <= link.sclk;
      sk_s2_q <= sk_s1_q;
      sk_s3_q <= sk_s2_q;
    end
  end

  // edges come a cycle late but clean; no raw pin reaches logic
  // select and clock share one delay, so their order is kept
  assign cs_fall = cs_s3_q && !cs_s2_q;
  assign cs_rise = !cs_s3_q && cs_s2_q;
  assign sk_fall = sk_s3_q && !sk_s2_q;
  assign sk_rise = !sk_s3_q && sk_s2_q;

  // ------------------------------------------------------------------
  // frame and power state
  // ------------------------------------------------------------------
  // counts are of serial clock falls only; rises matter just once
  asr_dev_state_type       st_q, st_d;       // frame sequencer
  logic [4:0]              cnt_q, cnt_d;     // falling edges seen
  logic [FRAME_BITS-1:0]   sh_q, sh_d;       // outgoing frame
  logic                    sdo_q, sdo_d;     // data pin
  logic                    oe_n_q, oe_n_d;   // low while driving
  logic                    track_d;          // track-and-hold mode
  logic                    asleep_q, asleep_d; // analog powered down
  logic                    wake_q, wake_d;   // power-up in progress
  logic                    done_d;           // frame complete pulse

  // sequencer next state
  always_comb begin
    // every value except the done pulse holds unless a branch below changes it
    st_d    = st_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    sdo_d   = sdo_q;
    oe_n_d  = oe_n_q;
    track_d = track_q;
    asleep_d = asleep_q;
    wake_d  = wake_q;
    done_d  = 1'b0;
    case (st_q)
      // select high: line released, serial clock has no effect
      D_IDLE: begin
        oe_n_d = 1'b1;
        if (cs_fall) begin
          // sample the input and show the first zero at once
          st_d    = D_CONV;
          cnt_d   = 5'h00;
          track_d = 1'b0;
          sh_d    = {2'b00, sample_in};
          sdo_d   = 1'b0;
          oe_n_d  = 1'b0;
          // a sleeping converter starts waking on this fall
          wake_d  = asleep_q;
        end
      end
      // converting and shifting on the host's clock
      D_CONV: begin
        if (cs_rise) begin
          // early rise ends the frame and lets go of the line
          st_d    = D_IDLE;
          oe_n_d  = 1'b1;
          // an aborted frame still returns the sampler to track
          track_d = 1'b1;
          wake_d  = 1'b0;
          // a rise before the second fall is taken as a glitch
          if (!asleep_q && cnt_q >= FALL_PD_LO
              && cnt_q < FALL_PD_HI) begin
            asleep_d = 1'b1;
          end
        end else begin
          // select still low: follow the serial clock
          if (sk_fall) begin
            cnt_d = cnt_q + 5'h01;
            sh_d  = {sh_q[FRAME_BITS-2:0], 1'b0};
            // the bit behind the one on the line goes out next
            sdo_d = sh_q[FRAME_BITS-2];
            // ten falls into a wake-up frame the analog side stays up
            if (cnt_d == FALL_PD_HI && wake_q) begin
              asleep_d = 1'b0;
            end
            // sixteenth fall: frame complete, let go of the line
            if (cnt_d == FALL_LAST) begin
              st_d   = D_DONE;
              oe_n_d = 1'b1;
              done_d = 1'b1;
              wake_d = 1'b0;
            end
          end
          // hold ends on the rise after the fifteenth fall
          if (sk_rise && cnt_q == FALL_TRACK) begin
            track_d = 1'b1;
          end
        end
      end
      // frame finished, select still low: wait for it to rise
      D_DONE: begin
        oe_n_d  = 1'b1;
        track_d = 1'b1;
        // further serial clocks are ignored until select rises
        if (cs_rise) begin
          st_d = D_IDLE;
        end
      end
      default: begin
        // unused code: recover to idle with the line released
        st_d   = D_IDLE;
        oe_n_d = 1'b1;
      end
    endcase
  end

  // sequencer registers
  // reset leaves the line released and the analog side powered
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q         <= D_IDLE;
      cnt_q        <= 5'h00;
      sh_q         <= '0;
      sdo_q        <= 1'b0;
      oe_n_q       <= 1'b1;
      track_q      <= 1'b1;
      asleep_q     <= 1'b0;
      wake_q       <= 1'b0;
      frame_done_q <= 1'b0;
      powered_q    <= 1'b1;
    end else begin
      st_q         <= st_d;
      cnt_q        <= cnt_d;
      sh_q         <= sh_d;
      sdo_q        <= sdo_d;
      oe_n_q       <= oe_n_d;
      track_q      <= track_d;
      asleep_q     <= asleep_d;
      wake_q       <= wake_d;
      frame_done_q <= done_d;
      // fully powered only once a wake-up frame has passed its tenth fall and ended
      powered_q    <= !asleep_d && !wake_d;
    end
  end

  // ------------------------------------------------------------------
  // pins; both come straight from flops, so the line never glitches
  // ------------------------------------------------------------------
  // the interface turns a released line into a high level
  assign link.serial_result_out = sdo_q;
  assign link.sdo_oe_n          = oe_n_q;

endmodule

/* File: rtl/asr_host.sv */
// host end: makes select and serial clock, collects result words
// assumes the data line comes from another domain; words leave through
// a two-entry buffer so a stalled reader loses nothing
`timescale 1ns/1ps
module asr_host
  import asr_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                resetn,
  asr_link_if.host                 link,
  input  wire logic                conv_req,
  input  wire logic                pd_req,
  output logic                     busy_q,
  output logic                     asleep_q,
  output logic [RES_BITS-1:0]      word_data,
  output logic                     word_valid,
  input  wire logic                word_ready
);

  // ------------------------------------------------------------------
  // data line synchroniser
  // ------------------------------------------------------------------
  logic sd_s1_q, sd_s2_q;   // second stage is the only one read

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sd_s1_q <= 1'b1;
      sd_s2_q <= 1'b1;
    end else begin
      sd_s1_q <= link.sdo_line;
      sd_s2_q <= sd_s1_q;
    end
  end

  // ------------------------------------------------------------------
  // frame sequencer
  // ------------------------------------------------------------------
  asr_host_state_type    st_q, st_d;     // frame state
  logic [7:0]            div_q, div_d;   // clock divider
  logic [4:0]            cnt_q, cnt_d;   // falling edges sent
  logic [4:0]            tgt_q, tgt_d;   // edges wanted this frame
  logic [FRAME_BITS-1:0] sr_q, sr_d;     // captured bits
  logic                  cs_q, cs_d;     // select pin
  logic                  sk_q, sk_d;     // serial clock pin
  logic                  drop_q, drop_d; // discard a wake-up frame
  logic                  push_q, push_d; // word into the buffer
  logic                  asleep_d;
  logic                  in_ready;

  // conversions start only when the buffer has room, so every push is taken
  always_comb begin
    st_d = st_q;
    div_d = div_q;
    cnt_d = cnt_q;
    tgt_d = tgt_q;
    sr_d = sr_q;
    cs_d = cs_q;
    sk_d = sk_q;
    drop_d = drop_q;
    push_d = 1'b0;
    asleep_d = asleep_q;
    case (st_q)
      H_IDLE: begin
        div_d = 8'h00;
        cnt_d = 5'h00;
        if (pd_req) begin
          st_d  = H_LEAD;
          cs_d  = 1'b0;
          tgt_d = FALL_BURST;
        end else if (conv_req && in_ready) begin
          st_d   = H_LEAD;
          cs_d   = 1'b0;
          tgt_d  = FALL_LAST;
          drop_d = asleep_q;
        end
      end
      // half a period from select low to the first falling edge
      H_LEAD: begin
        div_d = div_q + 8'h01;
        if (div_d == HALF_CYC) begin
          st_d  = H_RUN;
          div_d = 8'h00;
          sk_d  = 1'b0;
          cnt_d = 5'h01;
          sr_d  = {sr_q[FRAME_BITS-2:0], sd_s2_q};
        end
      end
      H_RUN: begin
        div_d = div_q + 8'h01;
        if (div_d == HALF_CYC) begin
          div_d = 8'h00;
          if (sk_q) begin
            sk_d  = 1'b0;
            cnt_d = cnt_q + 5'h01;
            sr_d  = {sr_q[FRAME_BITS-2:0], sd_s2_q};
          end else begin
            sk_d = 1'b1;
            if (cnt_q == tgt_q) begin
              st_d = H_QUIET;
              cs_d = 1'b1;
              if (tgt_q == FALL_LAST) begin
                push_d   = !drop_q;
                asleep_d = 1'b0;
              end else begin
                asleep_d = 1'b1;
              end
            end
          end
        end
      end
      // fixed gap holds select high at least QUIET_CYC cycles between frames
      H_QUIET: begin
        div_d = div_q + 8'h01;
        if (div_d == QUIET_CYC) begin
          st_d  = H_IDLE;
          div_d = 8'h00;
        end
      end
      default: begin
        st_d = H_IDLE;
        cs_d = 1'b1;
        sk_d = 1'b1;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= H_IDLE;
      div_q <= 8'h00;
      cnt_q <= 5'h00;
      tgt_q <= 5'h00;
      sr_q <= '0;
      cs_q <= 1'b1;
      sk_q <= 1'b1;
      drop_q <= 1'b0;
      push_q <= 1'b0;
      asleep_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      tgt_q <= tgt_d;
      sr_q <= sr_d;
      cs_q <= cs_d;
      sk_q <= sk_d;
      drop_q <= drop_d;
      push_q <= push_d;
      asleep_q <= asleep_d;
      busy_q <= (st_d != H_IDLE);
    end
  end

  assign link.cs_n = cs_q;
  assign link.sclk = sk_q;

  // ------------------------------------------------------------------
  // result buffer
  // ------------------------------------------------------------------
  asr_fifo2 #(.W(RES_BITS), .D(2)) u_buf (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_valid  (push_q),
    .in_ready  (in_ready),
    .in_data   (sr_q[RES_BITS-1:0]),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );
endmodule

/* File: verification/asr_link_sva.sv */
// checker for the serial link between the converter and host ends
// assumes both ends are design modules clocked by the same mclk
`timescale 1ns/1ps
module asr_link_sva
  import asr_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_result_out,
  input wire logic sdo_oe_n,
  input wire logic sdo_line
);
  // ------------------------------------------------------------------
  // helper: serial clock falls seen in the current frame
  // ------------------------------------------------------------------
  logic [4:0] fall_q;  // falls counted while selected
  logic [4:0] fall_d;
  logic       sclk_q;  // serial clock one cycle back
  logic       sclk_d;

  // clear on deselect so each frame starts from zero
  always_comb begin
    fall_d = fall_q;
    sclk_d = sclk;
    if (!resetn || cs_n) begin
      fall_d = 5'h00;
    end else if (sclk_q && !sclk) begin
      fall_d = fall_q + 5'h01;
    end
  end

  // registers only
  always_ff @(posedge mclk) begin
    fall_q <= fall_d;
    sclk_q <= sclk_d;
  end

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // ranges allow for the two-flop pin synchroniser plus the edge flop
  property p_idle_off;
    cs_n [*6] |-> sdo_oe_n;
  endproperty
  property p_start;
    $fell(cs_n) |-> ##[3:5] (!sdo_oe_n && !serial_result_out);
  endproperty
  property p_first;
    $fell(sclk) && !cs_n && fall_q == 5'h00 |-> ##[3:5]
      (!sdo_line && !sdo_oe_n);
  endproperty
  property p_end;
    $fell(sclk) && !cs_n && fall_q == 5'h0F |-> ##1 !sdo_oe_n
      ##[1:4] sdo_oe_n;
  endproperty
  property p_abort;
    $rose(cs_n) |-> ##[0:5] sdo_oe_n;
  endproperty
  property p_lead;
    $fell(cs_n) |-> ##10 ($fell(sclk) && !cs_n);
  endproperty
  property p_half;
    $changed(sclk) |=> $stable(sclk) [*8];
  endproperty
  property p_quiet;
    $rose(cs_n) |-> sclk ##1 cs_n [*8];
  endproperty
  property p_count;
    $rose(cs_n) |-> (fall_q == 5'h10 || fall_q == 5'h08);
  endproperty

  a_idle_off: assert property (p_idle_off)
    else $error("data line driven while deselected");
  a_start: assert property (p_start)
    else $error("no leading zero after select fall");
  a_first: assert property (p_first)
    else $error("second leading zero missing");
  a_end: assert property (p_end)
    else $error("line not released at sixteenth fall");
  a_abort: assert property (p_abort)
    else $error("line not released after select rise");
  a_lead: assert property (p_lead)
    else $error("first serial clock fall misplaced");
  a_half: assert property (p_half)
    else $error("serial clock half period too short");
  a_quiet: assert property (p_quiet)
    else $error("select rose without clock high and quiet gap");
  a_count: assert property (p_count)
    else $error("frame length not sixteen or eight falls");

  c_full: cover property ($fell(sclk) && !cs_n && fall_q == 5'h0F);
  c_burst: cover property ($rose(cs_n) && fall_q == 5'h08);
  c_start: cover property ($fell(cs_n));
endmodule

/* File: verification/tb_top.sv */
// self-checking bench: host and converter ends joined by one link,
// plus a second converter driven straight by the bench for aborts
`timescale 1ns/1ps
module tb_top
  import asr_pkg::*;
;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic                mclk, resetn;
  logic                conv_req, pd_req, word_ready;
  logic [RES_BITS-1:0] sample_in, word_data;
  logic                busy_q, asleep_q, word_valid;
  logic                track_q, powered_q, frame_done_q;
  logic                track2_q, powered2_q, done2_q;
  int                  err_total, checks, cyc;

  asr_link_if asr_link_if_i();
  asr_link_if asr_link_if_i2();  // bench plays the host here
  wire lk_cs_n = asr_link_if_i.cs_n;
  wire lk_sclk = asr_link_if_i.sclk;
  wire lk_line = asr_link_if_i.sdo_line;
  wire lk_oe_n = asr_link_if_i.sdo_oe_n;

  asr_host asr_host_i (.mclk(mclk), .resetn(resetn),
    .link(asr_link_if_i), .conv_req(conv_req), .pd_req(pd_req),
    .busy_q(busy_q), .asleep_q(asleep_q), .word_data(word_data),
    .word_valid(word_valid), .word_ready(word_ready));
  asr_device asr_device_i (.mclk(mclk), .resetn(resetn),
    .link(asr_link_if_i), .sample_in(sample_in), .track_q(track_q),
    .powered_q(powered_q), .frame_done_q(frame_done_q));
  asr_device asr_device_i2 (.mclk(mclk), .resetn(resetn),
    .link(asr_link_if_i2), .sample_in(sample_in), .track_q(track2_q),
    .powered_q(powered2_q), .frame_done_q(done2_q));
  asr_link_sva asr_link_sva_i (.mclk(mclk), .resetn(resetn),
    .cs_n(lk_cs_n), .sclk(lk_sclk),
    .serial_result_out(asr_link_if_i.serial_result_out),
    .sdo_oe_n(lk_oe_n), .sdo_line(lk_line));

  // ------------------------------------------------------------------
  // clock, timeout and shared tasks
  // ------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ceiling sits well above the roughly 3800 cycles the tests need
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  task automatic test_done();
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp1(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmpw(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // bounded wait for a select level on the main link
  task automatic wait_cs(input logic lvl);
    for (int i = 0; i < 100 && lk_cs_n !== lvl; i++) begin
      @(negedge mclk);
    end
  endtask

  // one host frame; captures the wire on both serial clock edges
  task automatic run_frame(input logic [13:0] v, input bit chk,
                           input bit pd, output int nf);
    logic [15:0] fw;
    logic [14:0] rw;
    logic        ps, t15, t16;
    int          nd;
    fw = '0;
    rw = '0;
    nd = 0;
    nf = 0;
    @(negedge mclk);
    sample_in = v;
    if (pd) pd_req = 1'b1;
    else conv_req = 1'b1;
    wait_cs(1'b0);
    conv_req = 1'b0;
    pd_req = 1'b0;
    cmp1("busy", 1'b1, busy_q);
    ps = lk_sclk;
    for (int i = 0; i < 400 && lk_cs_n !== 1'b1; i++) begin
      @(negedge mclk);
      if (ps === 1'b1 && lk_sclk === 1'b0) begin
        fw = {fw[14:0], lk_line};
        nf++;
        if (nf == 15) t15 = track_q;
        if (nf == 16) t16 = track_q;
      end
      // rising captures: rise 1 is the second zero, rise 15 the lsb
      if (ps === 1'b0 && lk_sclk === 1'b1 && nf < 16) begin
        rw = {rw[13:0], lk_line};
      end
      if (frame_done_q === 1'b1) nd++;
      ps = lk_sclk;
    end
    repeat (30) @(negedge mclk);
    cmp1("released", 1'b1, lk_oe_n);
    cmp1("idle again", 1'b0, busy_q);
    if (nf == 16) begin
      cmp1("hold at 15th fall", 1'b0, t15);
      cmp1("track at 16th fall", 1'b1, t16);
      cmpw("done pulses", 16'h0001, 16'(nd));
    end
    if (chk) begin
      cmpw("fall word", {2'b00, v}, fw);
      cmpw("rise word", {2'b00, v}, {1'b0, rw});
    end
  endtask

  // take one word from the host buffer
  task automatic pop(input logic [13:0] v);
    for (int i = 0; i < 50 && word_valid !== 1'b1; i++) begin
      @(negedge mclk);
    end
    cmpw("word", {2'b00, v}, {2'b00, word_data});
    word_ready = 1'b1;
    @(negedge mclk);
    word_ready = 1'b0;
    @(negedge mclk);
  endtask

  // bench-made frame on the second link, select rises after n falls
  task automatic drv2(input int n, output logic oe, output logic th);
    asr_link_if_i2.cs_n = 1'b0;
    repeat (10) @(negedge mclk);
    for (int i = 0; i < n; i++) begin
      asr_link_if_i2.sclk = 1'b0;
      repeat (10) @(negedge mclk);
      if (i == 0) oe = asr_link_if_i2.sdo_oe_n;
      if (i == 0) th = track2_q;
      asr_link_if_i2.sclk = 1'b1;
      repeat (10) @(negedge mclk);
    end
    asr_link_if_i2.cs_n = 1'b1;
    repeat (20) @(negedge mclk);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    cmp1("select idle", 1'b1, lk_cs_n);
    cmp1("line idle", 1'b1, lk_line);
    cmp1("track idle", 1'b1, track_q);
    cmp1("powered idle", 1'b1, powered_q);
    cmp1("buffer empty", 1'b0, word_valid);
  endtask

  // boundary and alternating codes, each read out and popped
  task automatic t_frames();
    logic [13:0] vals [4] = '{14'h3FFF, 14'h0000, 14'h2AAA, 14'h1555};
    int          nf;
    foreach (vals[i]) begin
      run_frame(vals[i], 1'b1, 1'b0, nf);
      cmpw("falls", 16'h0010, 16'(nf));
      pop(vals[i]);
    end
  endtask

  // stalled reader: two words fill the buffer, no third frame starts
  task automatic t_stall();
    int nf;
    run_frame(14'h0001, 1'b1, 1'b0, nf);
    run_frame(14'h2000, 1'b1, 1'b0, nf);
    conv_req = 1'b1;
    repeat (60) @(negedge mclk);
    cmp1("no frame when full", 1'b1, lk_cs_n);
    conv_req = 1'b0;
    pop(14'h0001);
    pop(14'h2000);
    cmp1("buffer drained", 1'b0, word_valid);
  endtask

  // burst, dummy wake frame, then a valid frame
  task automatic t_pd();
    int nf;
    run_frame(14'h0000, 1'b0, 1'b1, nf);
    cmpw("burst falls", 16'h0008, 16'(nf));
    cmp1("powered down", 1'b0, powered_q);
    cmp1("host asleep", 1'b1, asleep_q);
    run_frame(14'h0ABC, 1'b0, 1'b0, nf);
    cmp1("woken", 1'b1, powered_q);
    cmp1("host awake", 1'b0, asleep_q);
    cmp1("dummy dropped", 1'b0, word_valid);
    run_frame(14'h0ABC, 1'b1, 1'b0, nf);
    pop(14'h0ABC);
  endtask

  // early rises on the second link, plus clocking while deselected
  task automatic t_abort();
    logic oe, th;
    for (int i = 0; i < 4; i++) begin
      asr_link_if_i2.sclk = ~asr_link_if_i2.sclk;
      repeat (10) @(negedge mclk);
    end
    cmp1("ignored clock", 1'b1, asr_link_if_i2.sdo_oe_n);
    drv2(1, oe, th);
    cmp1("driving", 1'b0, oe);
    cmp1("hold", 1'b0, th);
    cmp1("rise before 2nd", 1'b1, powered2_q);
    cmp1("aborted line", 1'b1, asr_link_if_i2.sdo_oe_n);
    cmp1("track after abort", 1'b1, track2_q);
    drv2(2, oe, th);
    cmp1("rise after 2nd", 1'b0, powered2_q);
    drv2(9, oe, th);
    cmp1("stays asleep", 1'b0, powered2_q);
    drv2(16, oe, th);
    cmp1("wake frame", 1'b1, powered2_q);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    err_total = 0;
    checks = 0;
    cyc = 0;
    resetn = 1'b0;
    conv_req = 1'b0;
    pd_req = 1'b0;
    word_ready = 1'b0;
    sample_in = '0;
    asr_link_if_i2.cs_n = 1'b1;
    asr_link_if_i2.sclk = 1'b1;
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    @(negedge mclk);
    t_reset();
    t_frames();
    t_stall();
    t_pd();
    t_abort();
    test_done();
  end
endmodule
